/* rtl/mem_space_regs.vh */
// Contract
// - program location is 24 bits: low word even address, upper word odd, top byte empty.
// - program addresses are even and the program counter steps by two.
// - program addresses 00000h through 00020h are reserved for fixed vectors.
// - execution starts at 000000h after reset; jump target sits at 000002h.
// - vector tables occupy 000004h-0000FFh and 000100h-0001FFh.
// - last four program words hold configuration, copied to registers on every reset.
// - configuration words at 0057F8h-0057FEh or 00ABF8h-00ABFEh by memory size.
// - data space is one linear 16-bit space with separate read and write generators.
// - 16-bit byte addresses; bit 15 clear is memory, set is program window.
// - only 16 Kbytes implemented; accesses outside return zero.
// - low byte at even address, high byte at odd address.
// - post-increment pointer adds one for bytes, two for words.
// - byte read fetches the word, bit 0 picks the byte, placed low.
// - shared word decode, per-lane write strobes; byte writes touch one lane.
// - odd word access traps; faulting read still completes, valid in the same cycle the trap goes pending.
// - misaligned word write executes but the memory write is suppressed.
// - byte load into a working register keeps its high byte.
// - sign widening extends 8 to 16 bits; clear-upper zeroes the high byte.
// - 0000h-1FFFh is the near region, reached by a 13-bit direct field.
// - move instructions reach all data space with a 16-bit direct field.
// - status bit 2 maps program space into the upper data half when set.
// - 0000h-07FFh holds special registers; unused ones read zero.
`ifndef MEM_SPACE_REGS_VH
`define MEM_SPACE_REGS_VH
`define PC_RESET        23'h000000
`define PC_STEP         23'h000002
`define VEC_LAST        23'h000020
`define IVT_FIRST       23'h000004
`define IVT_LAST        23'h0000ff
`define AIVT_FIRST      23'h000100
`define AIVT_LAST       23'h0001ff
`define CFG_SMALL_FIRST 23'h0057f8
`define CFG_SMALL_LAST  23'h0057fe
`define CFG_LARGE_FIRST 23'h00abf8
`define CFG_LARGE_LAST  23'h00abfe
`define CFG_WORDS       4
`define DATA_WORDS      8192
`define DATA_TOP        16'h3fff
`define SFR_LAST        16'h07ff
`define NEAR_LAST       16'h1fff
`define NEAR_MASK       16'h1fff
`define WINDOW_BIT      15
`define STATUS_WINDOW   2
`define BYTE_STEP       16'h0001
`define WORD_STEP       16'h0002
`define SFR_SPAN        16'h0040
`endif

/* rtl/data_word_ram.v */
`timescale 1ns/1ps
`default_nettype none
`include "mem_space_regs.vh"
module data_word_ram (
  input  wire        clk_sys,
  input  wire [12:0] rdIndex,
  output reg  [15:0] rdWord,
  input  wire [12:0] wrIndex,
  input  wire [1:0]  wrLane,
  input  wire [15:0] wrWord
);
  reg [7:0] laneLo [0:`DATA_WORDS-1];
  reg [7:0] laneHi [0:`DATA_WORDS-1];

  // shared word decode, separate strobe per lane
  // lane strobes
  always @(posedge clk_sys) begin
    if (wrLane[0]) begin
      laneLo[wrIndex] <= wrWord[7:0];
    end
    if (wrLane[1]) begin
      laneHi[wrIndex] <= wrWord[15:8];
    end
    rdWord <= {laneHi[rdIndex], laneLo[rdIndex]};
  end
endmodule
`default_nettype wire

/* rtl/memory_space_access_unit.v */
`timescale 1ns/1ps
`default_nettype none
`include "mem_space_regs.vh"
module memory_space_access_unit #(
  parameter LARGE_VARIANT = 1
) (
  input  wire        clk_sys,
  input  wire        srst,
  // program counter control
  input  wire        pcAdvance,
  input  wire        pcRetreat,
  input  wire        pcLoad,
  input  wire [22:0] pcLoadValue,
  output reg  [22:0] pcAddr_reg,
  input  wire [22:0] progAddr,
  output wire        progVectorArea,
  output wire        progPrimaryTable,
  output wire        progAltTable,
  output wire        progConfigArea,
  output wire        progUpperWord,
  // configuration copy at reset
  output wire [22:0] cfgFetchAddr,
  output wire        cfgFetchValid,
  input  wire [23:0] cfgFetchData,
  output reg  [23:0] cfgWord0_reg,
  output reg  [23:0] cfgWord1_reg,
  output reg  [23:0] cfgWord2_reg,
  output reg  [23:0] cfgWord3_reg,
  output wire        cfgReady,
  // core status
  input  wire [15:0] coreStatus,
  // read address generator
  input  wire        rdReq,
  input  wire        rdByte,
  input  wire        rdDirect,
  input  wire        rdNearField,
  input  wire [15:0] rdAddr,
  input  wire        rdPostInc,
  output reg  [15:0] rdData_reg,
  output reg         rdValid_reg,
  output reg  [15:0] rdPtrNext_reg,
  output reg         rdWindow_reg,
  // write address generator
  input  wire        wrReq,
  input  wire        wrByte,
  input  wire        wrDirect,
  input  wire        wrNearField,
  input  wire [15:0] wrAddr,
  input  wire [15:0] wrData,
  input  wire        wrPostInc,
  output reg  [15:0] wrPtrNext_reg,
  // sfr side
  output wire        sfrRead,
  input  wire [15:0] sfrData,
  input  wire        sfrHit,
  // working register byte ops
  input  wire [15:0] regOld,
  input  wire [7:0]  regByteIn,
  input  wire        regByteLoad,
  input  wire        signWidenOp,
  input  wire        clearUpperByteOp,
  output reg  [15:0] regResult_reg,
  // exception
  output reg         addrError_reg,
  output reg         trapPending_reg
);
  localparam ST_RESET = 3'b001;
  localparam ST_COPY  = 3'b010;
  localparam ST_RUN   = 3'b100;

  wire [22:0] cfgFirst = LARGE_VARIANT ? `CFG_LARGE_FIRST : `CFG_SMALL_FIRST;
  wire [22:0] cfgLast  = LARGE_VARIANT ? `CFG_LARGE_LAST : `CFG_SMALL_LAST;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [1:0] cfgIdx_reg;
  reg       copyWait_reg;

  // direct-address field: near field keeps 13 bits, move form keeps 16
  function [15:0] direct_addr;
    input        isNear;
    input [15:0] a;
    begin
      direct_addr = isNear ? (a & `NEAR_MASK) : a;
    end
  endfunction

  function [15:0] post_step;
    input [15:0] a;
    input        isByte;
    begin
      post_step = a + (isByte ? `BYTE_STEP : `WORD_STEP);
    end
  endfunction

  function in_ram;
    input [15:0] a;
    begin
      in_ram = (a <= `DATA_TOP);
    end
  endfunction

  assign progUpperWord   = progAddr[0];
  assign progVectorArea  = (progAddr <= `VEC_LAST);
  assign progPrimaryTable = (progAddr >= `IVT_FIRST) && (progAddr <= `IVT_LAST);
  assign progAltTable     = (progAddr >= `AIVT_FIRST) && (progAddr <= `AIVT_LAST);
  assign progConfigArea  = (progAddr >= cfgFirst) && (progAddr <= cfgLast);

  always @* begin
    case (state_reg)
      ST_RESET: state_next = ST_COPY;
      ST_COPY:  state_next = (copyWait_reg && cfgIdx_reg == 2'd3) ? ST_RUN : ST_COPY;
      ST_RUN:   state_next = ST_RUN;
      default:  state_next = ST_RESET;
    endcase
  end

  assign cfgFetchAddr  = cfgFirst + {20'h00000, cfgIdx_reg, 1'b0};
  assign cfgFetchValid = (state_reg == ST_COPY) && !copyWait_reg;
  assign cfgReady      = (state_reg == ST_RUN);

  always @(posedge clk_sys) begin
    if (srst) begin
      state_reg    <= ST_RESET;
      cfgIdx_reg   <= 2'd0;
      copyWait_reg <= 1'b0;
      cfgWord0_reg <= 24'h000000;
      cfgWord1_reg <= 24'h000000;
      cfgWord2_reg <= 24'h000000;
      cfgWord3_reg <= 24'h000000;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_COPY) begin
        copyWait_reg <= !copyWait_reg;
        if (copyWait_reg) begin
          // upper byte of the upper word is not implemented
          case (cfgIdx_reg)
            2'd0:    cfgWord0_reg <= {8'h00, cfgFetchData[15:0]};
            2'd1:    cfgWord1_reg <= {8'h00, cfgFetchData[15:0]};
            2'd2:    cfgWord2_reg <= {8'h00, cfgFetchData[15:0]};
            default: cfgWord3_reg <= {8'h00, cfgFetchData[15:0]};
          endcase
          cfgIdx_reg <= cfgIdx_reg + 2'd1;
        end
      end
    end
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      pcAddr_reg <= `PC_RESET;
    end else if (cfgReady) begin
      if (pcLoad) begin
        pcAddr_reg <= {pcLoadValue[22:1], 1'b0};
      end else if (pcAdvance) begin
        pcAddr_reg <= pcAddr_reg + `PC_STEP;
      end else if (pcRetreat) begin
        pcAddr_reg <= pcAddr_reg - `PC_STEP;
      end
    end
  end

  wire [15:0] rdEa = rdDirect ? direct_addr(rdNearField, rdAddr) : rdAddr;
  wire [15:0] wrEa = wrDirect ? direct_addr(wrNearField, wrAddr) : wrAddr;

  wire rdMisalign = rdReq && !rdByte && rdEa[0];
  wire wrMisalign = wrReq && !wrByte && wrEa[0];

  wire programWindowEnable = coreStatus[`STATUS_WINDOW];
  wire rdInWindow = rdEa[`WINDOW_BIT];
  wire rdIsSfr    = (rdEa <= `SFR_LAST);
  wire wrIsSfr    = (wrEa <= `SFR_LAST);

  assign sfrRead = rdReq && rdIsSfr;

  wire       wrHitRam = wrReq && !wrMisalign && !wrIsSfr && in_ram(wrEa);
  wire [1:0] wrLane   = !wrHitRam ? 2'b00 :
                        (!wrByte ? 2'b11 : (wrEa[0] ? 2'b10 : 2'b01));
  wire [15:0] wrWordIn = wrByte ? {wrData[7:0], wrData[7:0]} : wrData;

  wire [15:0] ramWord;
  data_word_ram ram (
    .clk_sys (clk_sys),
    .rdIndex (rdEa[13:1]),
    .rdWord  (ramWord),
    .wrIndex (wrEa[13:1]),
    .wrLane  (wrLane),
    .wrWord  (wrWordIn)
  );

  // one-cycle read stage, ram output lines up with these
  reg        rdPend_reg;
  reg        rdSel_reg;
  reg        rdSfr_reg;
  reg        rdRam_reg;
  reg        rdByteQ_reg;

  always @(posedge clk_sys) begin
    if (srst) begin
      rdPend_reg  <= 1'b0;
      rdSel_reg   <= 1'b0;
      rdSfr_reg   <= 1'b0;
      rdRam_reg   <= 1'b0;
      rdByteQ_reg <= 1'b0;
    end else begin
      rdPend_reg  <= rdReq;
      rdSel_reg   <= rdEa[0];
      rdSfr_reg   <= rdIsSfr && sfrHit;
      rdRam_reg   <= !rdIsSfr && in_ram(rdEa) && !rdInWindow;
      rdByteQ_reg <= rdByte;
    end
  end

  reg [15:0] sfrHold_reg;
  always @(posedge clk_sys) begin
    if (srst) begin
      sfrHold_reg <= 16'h0000;
    end else begin
      sfrHold_reg <= (rdIsSfr && sfrHit) ? sfrData : 16'h0000;
    end
  end

  wire [15:0] rawWord = rdSfr_reg ? sfrHold_reg : (rdRam_reg ? ramWord : 16'h0000);

  always @(posedge clk_sys) begin
    if (srst) begin
      rdData_reg    <= 16'h0000;
      rdValid_reg   <= 1'b0;
      rdPtrNext_reg <= 16'h0000;
      wrPtrNext_reg <= 16'h0000;
      rdWindow_reg  <= 1'b0;
    end else begin
      // faulting reads still complete, valid in the same cycle as trapPending_reg
      rdValid_reg <= rdPend_reg;
      if (rdByteQ_reg) begin
        rdData_reg <= {8'h00, rdSel_reg ? rawWord[15:8] : rawWord[7:0]};
      end else begin
        rdData_reg <= rawWord;
      end
      // window hand-off only when mapping is on
      rdWindow_reg <= rdReq && rdInWindow && programWindowEnable;
      if (rdReq && rdPostInc) begin
        rdPtrNext_reg <= post_step(rdAddr, rdByte);
      end
      if (wrReq && wrPostInc) begin
        wrPtrNext_reg <= post_step(wrAddr, wrByte);
      end
    end
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      addrError_reg   <= 1'b0;
      trapPending_reg <= 1'b0;
    end else begin
      addrError_reg   <= rdMisalign || wrMisalign;
      trapPending_reg <= addrError_reg;
    end
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      regResult_reg <= 16'h0000;
    end else if (signWidenOp) begin
      regResult_reg <= {{8{regOld[7]}}, regOld[7:0]};
    end else if (clearUpperByteOp) begin
      regResult_reg <= {8'h00, regOld[7:0]};
    end else if (regByteLoad) begin
      regResult_reg <= {regOld[15:8], regByteIn};
    end else begin
      regResult_reg <= regOld;
    end
  end
endmodule
`default_nettype wire

/* bench/prog_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
module prog_flash_model (
  input  wire logic        clk_sys,
  input  wire logic        cfgFetchValid,
  input  wire logic [22:0] cfgFetchAddr,
  output logic      [23:0] cfgFetchData,
  input  wire logic        sfrRead,
  input  wire logic        hitEn,
  output logic             sfrHit,
  output logic      [15:0] sfrData
);
  logic [15:0] spin = 16'h0001;
  // config word answer
  // valid only in the cycle after the fetch; a moving pattern otherwise
  always @(posedge clk_sys) begin
    spin <= spin + 16'h3c5b;
    if (cfgFetchValid)
      cfgFetchData <= {8'h00, cfgFetchAddr[15:0] ^ 16'h5a5a};
    else
      cfgFetchData <= {~spin[7:0], spin};
  end
  assign sfrHit = sfrRead & hitEn;
  assign sfrData = sfrHit ? 16'h00c1 : spin;
endmodule
`default_nettype wire

/* bench/memory_space_access_unit_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module memory_space_access_unit_chk (
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        rdReq,
  input wire logic        rdByte,
  input wire logic        rdDirect,
  input wire logic [15:0] rdAddr,
  input wire logic        rdPostInc,
  input wire logic [15:0] rdData_reg,
  input wire logic        rdValid_reg,
  input wire logic [15:0] rdPtrNext_reg,
  input wire logic        wrReq,
  input wire logic        wrByte,
  input wire logic [15:0] wrAddr,
  input wire logic        wrPostInc,
  input wire logic [15:0] wrPtrNext_reg,
  input wire logic        addrError_reg,
  input wire logic        trapPending_reg
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  chk_err_write:
    assert property (wrReq && !wrByte && wrAddr[0] |=> addrError_reg)
    else $error("no error after odd word write");
  chk_err_read:
    assert property (rdReq && !rdByte && rdAddr[0] |=> addrError_reg)
    else $error("no error after odd word read");
  chk_err_cause:
    assert property (addrError_reg |-> $past((rdReq && !rdByte && rdAddr[0])
      || (wrReq && !wrByte && wrAddr[0])))
    else $error("error without odd word access");
  chk_trap_follow:
    assert property (addrError_reg |=> trapPending_reg)
    else $error("trap did not follow error");
  chk_rd_latency:
    assert property (rdReq |-> ##2 rdValid_reg)
    else $error("read answer late");
  chk_byte_low:
    assert property (rdValid_reg && $past(rdReq && rdByte, 2) |-> rdData_reg[15:8] == 8'h00)
    else $error("byte read upper not zero");
  chk_out_zero:
    assert property (rdValid_reg && $past(rdReq && !rdDirect && rdAddr[15:14] != 2'b00, 2)
      |-> rdData_reg == 16'h0000)
    else $error("outside read not zero");
  chk_rd_step:
    assert property (rdReq && rdByte && rdPostInc |=> rdPtrNext_reg == $past(rdAddr) + 16'h0001)
    else $error("byte pointer step wrong");
  chk_wr_step:
    assert property (wrReq && !wrByte && wrPostInc |=> wrPtrNext_reg == $past(wrAddr) + 16'h0002)
    else $error("word pointer step wrong");
endmodule
bind memory_space_access_unit memory_space_access_unit_chk chk (.clk_sys, .srst, .rdReq,
  .rdByte, .rdDirect, .rdAddr, .rdPostInc, .rdData_reg, .rdValid_reg, .rdPtrNext_reg, .wrReq,
  .wrByte, .wrAddr, .wrPostInc, .wrPtrNext_reg, .addrError_reg, .trapPending_reg);
`default_nettype wire

/* bench/memory_space_access_unit_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module memory_space_access_unit_tb;
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic        pcAdvance, pcRetreat, pcLoad, rdReq, rdByte, rdDirect, rdNearField;
  logic        rdPostInc, wrReq, wrByte, wrDirect, wrNearField, wrPostInc, hitEn;
  logic        regByteLoad, signWidenOp, clearUpperByteOp, cfgFetchValid, cfgReady;
  logic        progVectorArea, progPrimaryTable, progAltTable, progConfigArea;
  logic        progUpperWord, rdValid_reg, rdWindow_reg, sfrRead, sfrHit;
  logic        addrError_reg, trapPending_reg;
  logic [22:0] pcLoadValue, pcAddr_reg, progAddr, cfgFetchAddr;
  logic [23:0] cfgFetchData, cfgWord0_reg, cfgWord1_reg, cfgWord2_reg, cfgWord3_reg;
  logic [15:0] coreStatus, rdAddr, wrAddr, wrData, sfrData, regOld, regResult_reg;
  logic [15:0] rdData_reg, rdPtrNext_reg, wrPtrNext_reg;
  logic [7:0]  regByteIn;
  int          err_count = 0;
  int          n_compared = 0;
  int          cycles = 0;

  memory_space_access_unit #(.LARGE_VARIANT(1)) dut (.clk_sys, .srst, .pcAdvance, .pcRetreat,
    .pcLoad, .pcLoadValue, .pcAddr_reg, .progAddr, .progVectorArea, .progPrimaryTable,
    .progAltTable, .progConfigArea, .progUpperWord, .cfgFetchAddr, .cfgFetchValid,
    .cfgFetchData, .cfgWord0_reg, .cfgWord1_reg, .cfgWord2_reg, .cfgWord3_reg, .cfgReady,
    .coreStatus, .rdReq, .rdByte, .rdDirect, .rdNearField, .rdAddr, .rdPostInc, .rdData_reg,
    .rdValid_reg, .rdPtrNext_reg, .rdWindow_reg, .wrReq, .wrByte, .wrDirect, .wrNearField,
    .wrAddr, .wrData, .wrPostInc, .wrPtrNext_reg, .sfrRead, .sfrData, .sfrHit, .regOld,
    .regByteIn, .regByteLoad, .signWidenOp, .clearUpperByteOp, .regResult_reg,
    .addrError_reg, .trapPending_reg);
  prog_flash_model flash (.clk_sys, .cfgFetchValid, .cfgFetchAddr, .cfgFetchData, .sfrRead,
    .hitEn, .sfrHit, .sfrData);

  always #5 clk_sys = ~clk_sys;

  task automatic final_report;
    if (err_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      $display("BAD %0t timeout", $time);
      final_report;
    end
  end

  task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic rd(input logic [15:0] a, input logic b, input logic [1:0] m, input logic w,
                    input logic [15:0] e);
    @(posedge clk_sys);
    rdReq <= 1'b1;
    rdAddr <= a;
    rdByte <= b;
    {rdDirect, rdNearField} <= m;
    rdPostInc <= 1'b1;
    @(posedge clk_sys);
    rdReq <= 1'b0;
    // window flag stands in the cycle after the request, data one cycle later
    #1;
    chk(rdWindow_reg, w, "window");
    @(posedge clk_sys);
    #1;
    chk({rdValid_reg, rdData_reg}, {1'b1, e}, "read");
  endtask

  task automatic wr(input logic [15:0] a, input logic b, input logic [15:0] d);
    @(posedge clk_sys);
    wrReq <= 1'b1;
    wrAddr <= a;
    wrByte <= b;
    wrData <= d;
    wrPostInc <= 1'b1;
    @(posedge clk_sys);
    wrReq <= 1'b0;
  endtask

  task automatic t_boot;
    #1;
    chk(pcAddr_reg, 48'h0, "reset pc");
    repeat (40) if (cfgReady !== 1'b1) begin
      @(posedge clk_sys);
      #1;
    end
    chk({cfgWord0_reg, cfgWord1_reg}, {24'h00f1a2, 24'h00f1a0}, "cfg lo");
    chk({cfgWord2_reg, cfgWord3_reg}, {24'h00f1a6, 24'h00f1a4}, "cfg hi");
  endtask

  task t_decode;
    logic [22:0] pa [9] = '{23'h0, 23'h20, 23'h21, 23'h3, 23'h1ff, 23'h100, 23'h200,
                            23'habfe, 23'h57f8};
    logic [4:0]  pe [9] = '{5'h10, 5'h18, 5'h09, 5'h11, 5'h05, 5'h04, 5'h00, 5'h02, 5'h00};
    foreach (pa[i]) begin
      @(posedge clk_sys);
      progAddr <= pa[i];
      #1;
      chk({progVectorArea, progPrimaryTable, progAltTable, progConfigArea, progUpperWord},
          pe[i], "decode");
    end
  endtask

  task automatic t_pc;
    @(posedge clk_sys);
    pcLoad <= 1'b1;
    pcLoadValue <= 23'h000123;
    @(posedge clk_sys);
    pcLoad <= 1'b0;
    pcAdvance <= 1'b1;
    #1;
    chk(pcAddr_reg, 48'h122, "pc load");
    @(posedge clk_sys);
    pcAdvance <= 1'b0;
    pcRetreat <= 1'b1;
    #1;
    chk(pcAddr_reg, 48'h124, "pc advance");
    @(posedge clk_sys);
    pcRetreat <= 1'b0;
    #1;
    chk(pcAddr_reg, 48'h122, "pc retreat");
  endtask

  task automatic t_data;
    wr(16'h0900, 1'b0, 16'hbeef);
    wr(16'h0901, 1'b1, 16'h5512);
    wr(16'h2900, 1'b0, 16'ha5c3);
    rd(16'h0900, 1'b0, 2'b00, 1'b0, 16'h12ef);
    rd(16'h0901, 1'b1, 2'b00, 1'b0, 16'h0012);
    rd(16'h2900, 1'b0, 2'b11, 1'b0, 16'h12ef);
    rd(16'h2900, 1'b0, 2'b10, 1'b0, 16'ha5c3);
    rd(16'h4000, 1'b0, 2'b00, 1'b0, 16'h0000);
    @(posedge clk_sys);
    {wrDirect, wrNearField} <= 2'b11;
    wr(16'h2904, 1'b0, 16'h6c6c);
    {wrDirect, wrNearField} <= 2'b00;
    rd(16'h0904, 1'b0, 2'b00, 1'b0, 16'h6c6c);
    @(posedge clk_sys);
    coreStatus <= 16'h0004;
    hitEn <= 1'b1;
    rd(16'h8000, 1'b0, 2'b00, 1'b1, 16'h0000);
    rd(16'h0040, 1'b0, 2'b00, 1'b0, 16'h00c1);
    @(posedge clk_sys);
    coreStatus <= 16'h0000;
    hitEn <= 1'b0;
    rd(16'h8000, 1'b0, 2'b00, 1'b0, 16'h0000);
    rd(16'h0040, 1'b0, 2'b00, 1'b0, 16'h0000);
  endtask

  task automatic t_err;
    wr(16'h0902, 1'b0, 16'h1357);
    wr(16'h0903, 1'b0, 16'h7777);
    #1;
    chk({addrError_reg, trapPending_reg}, 48'h2, "error pulse");
    @(posedge clk_sys);
    #1;
    chk({addrError_reg, trapPending_reg}, 48'h1, "trap pulse");
    rd(16'h0902, 1'b0, 2'b00, 1'b0, 16'h1357);
    rd(16'h0903, 1'b0, 2'b00, 1'b0, 16'h1357);
  endtask

  task automatic rop(input logic [2:0] op, input logic [15:0] o, input logic [7:0] b,
                     input logic [15:0] e);
    @(posedge clk_sys);
    {signWidenOp, clearUpperByteOp, regByteLoad} <= op;
    regOld <= o;
    regByteIn <= b;
    @(posedge clk_sys);
    {signWidenOp, clearUpperByteOp, regByteLoad} <= 3'b000;
    #1;
    chk(regResult_reg, e, "reg op");
  endtask

  task automatic t_reg;
    rop(3'b001, 16'h1234, 8'h9a, 16'h129a);
    rop(3'b100, 16'h569a, 8'h9a, 16'hff9a);
    rop(3'b010, 16'h569a, 8'h9a, 16'h009a);
  endtask

  // a second reset must restart at zero and copy the configuration again
  task automatic t_again;
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    t_boot;
  endtask

  initial begin
    {pcAdvance, pcRetreat, pcLoad, rdReq, rdByte, rdDirect, rdNearField, rdPostInc} = '0;
    {wrReq, wrByte, wrDirect, wrNearField, wrPostInc, hitEn} = '0;
    {regByteLoad, signWidenOp, clearUpperByteOp, pcLoadValue, progAddr} = '0;
    {coreStatus, rdAddr, wrAddr, wrData, regOld, regByteIn} = '0;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    t_boot;
    t_decode;
    t_pc;
    t_data;
    t_err;
    t_reg;
    t_again;
    final_report;
  end
endmodule
`default_nettype wire
